// File: design/sdpr_cfg.svh
`ifndef SDPR_CFG_SVH
`define SDPR_CFG_SVH

// ----------------------------------------------------------------------------
// Special-function register space.
// ----------------------------------------------------------------------------
`define SDPR_SFR_BASE      8'h80
`define SDPR_OFF_STACK_TOP 8'h81
`define SDPR_OFF_DP_LOW    8'h82
`define SDPR_OFF_DP_HIGH   8'h83

// ----------------------------------------------------------------------------
// Reset values.
// ----------------------------------------------------------------------------
`define SDPR_RST_STACK_TOP 8'h07
`define SDPR_RST_DP_LOW    8'h07
`define SDPR_RST_DP_HIGH   8'h07

// ----------------------------------------------------------------------------
// Stack step and unmapped read value.
// ----------------------------------------------------------------------------
`define SDPR_STACK_STEP    8'h01
`define SDPR_UNMAPPED_READ 8'h00

`endif

// File: design/sdpr_pkg.sv
// ----------------------------------------------------------------------------
// Types shared by the pointer register file.
// ----------------------------------------------------------------------------
package sdpr_pkg;

  // Stack operation requested by the core.
  typedef enum logic [2:0] {
    SDPR_OP_NONE = 3'h1,
    SDPR_OP_PUSH = 3'h2,
    SDPR_OP_POP  = 3'h4
  } sdpr_stack_op_t;

  // Direct-addressed special-function register access from the core.
  typedef struct packed {
    logic       wr_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sdpr_sfr_req_t;

  // Stack memory request handed to the data RAM.
  typedef struct packed {
    logic       wr_en;
    logic       rd_en;
    logic [7:0] addr;
  } sdpr_stack_mem_t;

endpackage

// File: design/sdpr_byte_reg.sv
`timescale 1ns/1ps
`include "sdpr_cfg.svh"

// ----------------------------------------------------------------------------
// One 8-bit pointer byte with a synchronous reset value and a load port.
// ----------------------------------------------------------------------------
module sdpr_byte_reg #(
  parameter logic [7:0] RESET_VALUE = 8'h00
) (
  input  wire logic       i_clk,
  input  wire logic       i_rstn,
  input  wire logic       i_load,
  input  wire logic [7:0] i_value,
  output logic      [7:0] o_value
);

  logic [7:0] next_value;  // Value taken at the next edge.

  // Hold unless loaded.
  always_comb begin
    next_value = o_value;
    if (i_load) begin
      next_value = i_value;
    end
  end

  // Synchronous reset to the constant reset value.
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_value <= RESET_VALUE;
    end else begin
      o_value <= next_value;
    end
  end

endmodule

// File: design/sdpr_regs.sv
`timescale 1ns/1ps
`include "sdpr_cfg.svh"

module sdpr_regs (
  input  wire logic                     i_clk,
  input  wire logic                     i_rstn,
  input  wire sdpr_pkg::sdpr_sfr_req_t  i_sfr_req,
  input  wire sdpr_pkg::sdpr_stack_op_t i_stack_op,
  output logic                   [7:0]  o_sfr_rdata,
  output logic                          o_sfr_hit,
  output logic                   [7:0]  o_stack_top_pointer,
  output logic                  [15:0]  o_wide_data_pointer,
  output sdpr_pkg::sdpr_stack_mem_t     o_stack_mem
);

  // --------------------------------------------------------------------------
  // Address decode.
  // --------------------------------------------------------------------------
  logic       in_sfr_space;   // Direct address lies in the SFR half.
  logic       hit_stack;      // Access targets the stack pointer.
  logic       hit_dp_low;     // Access targets the low pointer byte.
  logic       hit_dp_high;    // Access targets the high pointer byte.
  logic [7:0] stack_q;        // Stack pointer byte.
  logic [7:0] dp_low_q;       // Low data pointer byte.
  logic [7:0] dp_high_q;      // High data pointer byte.
  logic [7:0] stack_d;        // Next stack pointer value.
  logic       stack_ld;       // Stack pointer loads this edge.
  logic [7:0] next_rdata;     // Next read data.
  logic       next_hit;       // Next hit flag.
  logic [15:0] next_wide;     // Next wide data pointer.
  sdpr_pkg::sdpr_stack_mem_t next_mem;  // Next stack memory request.

  // Only direct addresses at or above the SFR base can reach these bytes.
  always_comb begin
    in_sfr_space = i_sfr_req.addr >= `SDPR_SFR_BASE;
    hit_stack    = in_sfr_space && (i_sfr_req.addr == `SDPR_OFF_STACK_TOP);
    hit_dp_low   = in_sfr_space && (i_sfr_req.addr == `SDPR_OFF_DP_LOW);
    hit_dp_high  = in_sfr_space && (i_sfr_req.addr == `SDPR_OFF_DP_HIGH);
  end

  // --------------------------------------------------------------------------
  // Stack pointer update.
  // --------------------------------------------------------------------------
  // A stack operation wins over a direct write in the same cycle, because the
  // core never issues both; the choice keeps the push address consistent.
  always_comb begin
    stack_d  = stack_q;
    stack_ld = 1'b0;
    case (i_stack_op)
      sdpr_pkg::SDPR_OP_PUSH: begin
        stack_d  = stack_q + `SDPR_STACK_STEP;
        stack_ld = 1'b1;
      end
      sdpr_pkg::SDPR_OP_POP: begin
        stack_d  = stack_q - `SDPR_STACK_STEP;
        stack_ld = 1'b1;
      end
      sdpr_pkg::SDPR_OP_NONE: begin
        // Only a direct write moves the pointer here; an idle cycle must leave
        // both the byte and its mirrored output untouched.
        if (i_sfr_req.wr_en && hit_stack) begin
          stack_d  = i_sfr_req.wdata;
          stack_ld = 1'b1;
        end
      end
      default: begin
        stack_d  = stack_q;
        stack_ld = 1'b0;
      end
    endcase
  end

  // Pointer bytes: all eight bits are live, so no reserved bits exist today;
  // any added later would reset to their bits of RESET_VALUE inside the byte register.
  sdpr_byte_reg #(.RESET_VALUE(`SDPR_RST_STACK_TOP)) u_stack (
    .i_clk   (i_clk),
    .i_rstn  (i_rstn),
    .i_load  (stack_ld),
    .i_value (stack_d),
    .o_value (stack_q)
  );

  sdpr_byte_reg #(.RESET_VALUE(`SDPR_RST_DP_LOW)) u_dp_low (
    .i_clk   (i_clk),
    .i_rstn  (i_rstn),
    .i_load  (i_sfr_req.wr_en && hit_dp_low),
    .i_value (i_sfr_req.wdata),
    .o_value (dp_low_q)
  );

  sdpr_byte_reg #(.RESET_VALUE(`SDPR_RST_DP_HIGH)) u_dp_high (
    .i_clk   (i_clk),
    .i_rstn  (i_rstn),
    .i_load  (i_sfr_req.wr_en && hit_dp_high),
    .i_value (i_sfr_req.wdata),
    .o_value (dp_high_q)
  );

  // --------------------------------------------------------------------------
  // Read data and stack memory request.
  // --------------------------------------------------------------------------
  // Reads return the current byte; unmapped addresses return zero.
  always_comb begin
    next_hit   = hit_stack || hit_dp_low || hit_dp_high;
    next_rdata = `SDPR_UNMAPPED_READ;
    if (hit_stack) begin
      next_rdata = stack_q;
    end else if (hit_dp_low) begin
      next_rdata = dp_low_q;
    end else if (hit_dp_high) begin
      next_rdata = dp_high_q;
    end
    // The wide output shows the bytes as they will stand after this edge.
    next_wide = {dp_high_q, dp_low_q};
    if (i_sfr_req.wr_en && hit_dp_high) begin
      next_wide[15:8] = i_sfr_req.wdata;
    end
    if (i_sfr_req.wr_en && hit_dp_low) begin
      next_wide[7:0] = i_sfr_req.wdata;
    end
    next_mem.wr_en = i_stack_op == sdpr_pkg::SDPR_OP_PUSH;
    next_mem.rd_en = i_stack_op == sdpr_pkg::SDPR_OP_POP;
    next_mem.addr  = stack_q;
    if (i_stack_op == sdpr_pkg::SDPR_OP_PUSH) begin
      next_mem.addr = stack_q + `SDPR_STACK_STEP;
    end
  end

  // All outputs come from flip-flops, one cycle after the request.
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_sfr_rdata         <= `SDPR_UNMAPPED_READ;
      o_sfr_hit           <= 1'b0;
      o_stack_mem         <= '0;
      o_stack_top_pointer <= `SDPR_RST_STACK_TOP;
      o_wide_data_pointer <= {`SDPR_RST_DP_HIGH, `SDPR_RST_DP_LOW};
    end else begin
      o_sfr_rdata         <= next_rdata;
      o_sfr_hit           <= next_hit;
      o_stack_mem         <= next_mem;
      o_stack_top_pointer <= stack_d;
      o_wide_data_pointer <= next_wide;
    end
  end

  // --------------------------------------------------------------------------
  // Assertions.
  // --------------------------------------------------------------------------
  property p_push_inc;
    @(posedge i_clk) disable iff (!i_rstn)
    i_stack_op == sdpr_pkg::SDPR_OP_PUSH |=> stack_q == $past(stack_q) + 8'h01;
  endproperty
  a_push_inc: assert property (p_push_inc) else $error("Push did not increment.");

  property p_push_addr;
    @(posedge i_clk) disable iff (!i_rstn)
    i_stack_op == sdpr_pkg::SDPR_OP_PUSH |=>
      o_stack_mem.wr_en && o_stack_mem.addr == stack_q;
  endproperty
  a_push_addr: assert property (p_push_addr) else $error("Push address wrong.");

  property p_pop;
    @(posedge i_clk) disable iff (!i_rstn)
    i_stack_op == sdpr_pkg::SDPR_OP_POP |=>
      o_stack_mem.rd_en && o_stack_mem.addr == stack_q + 8'h01;
  endproperty
  a_pop: assert property (p_pop) else $error("Pop address or decrement wrong.");

  property p_reset;
    @(posedge i_clk) !i_rstn |=> stack_q == 8'h07;
  endproperty
  a_reset: assert property (p_reset) else $error("Stack reset value wrong.");

  property p_sp_write;
    @(posedge i_clk) disable iff (!i_rstn)
    i_sfr_req.wr_en && i_sfr_req.addr == 8'h81 && i_stack_op == sdpr_pkg::SDPR_OP_NONE
      ##1 i_sfr_req.addr == 8'h81 && !i_sfr_req.wr_en
      |=> o_sfr_rdata == $past(i_sfr_req.wdata, 2);
  endproperty
  a_sp_write: assert property (p_sp_write) else $error("Stack readback wrong.");

  property p_dpl;
    @(posedge i_clk) disable iff (!i_rstn)
    i_sfr_req.wr_en && i_sfr_req.addr == 8'h82 |=> dp_low_q == $past(i_sfr_req.wdata);
  endproperty
  a_dpl: assert property (p_dpl) else $error("Low pointer byte not written.");

  property p_dph;
    @(posedge i_clk) disable iff (!i_rstn)
    i_sfr_req.wr_en && i_sfr_req.addr == 8'h83 |=> dp_high_q == $past(i_sfr_req.wdata);
  endproperty
  a_dph: assert property (p_dph) else $error("High pointer byte not written.");

  property p_wide;
    @(posedge i_clk) disable iff (!i_rstn)
    o_wide_data_pointer == {dp_high_q, dp_low_q};
  endproperty
  a_wide: assert property (p_wide) else $error("Wide pointer mismatch.");

  // The pointer output must never drift from the pointer byte it mirrors.
  property p_pointer_out;
    @(posedge i_clk) disable iff (!i_rstn)
    o_stack_top_pointer == stack_q;
  endproperty
  a_pointer_out: assert property (p_pointer_out) else $error("Stale pointer.");

  property p_low_space;
    @(posedge i_clk) disable iff (!i_rstn)
    i_sfr_req.addr < 8'h80 |=> !o_sfr_hit && o_sfr_rdata == 8'h00;
  endproperty
  a_low_space: assert property (p_low_space) else $error("Low address hit SFR.");

  c_push: cover property (@(posedge i_clk) i_stack_op == sdpr_pkg::SDPR_OP_PUSH);
  c_pop: cover property (@(posedge i_clk) i_stack_op == sdpr_pkg::SDPR_OP_POP);
  c_dph_wr: cover property (@(posedge i_clk) i_sfr_req.wr_en && hit_dp_high);
  c_wrap: cover property (@(posedge i_clk)
    stack_q == 8'hFF && i_stack_op == sdpr_pkg::SDPR_OP_PUSH);

endmodule

// File: testbench/sdpr_stack_ram_model.sv
`timescale 1ns/1ps

// ---------------------------------------------
// Stack RAM on the far side of the pointers.
// ---------------------------------------------
module sdpr_stack_ram_model (
  input  wire logic                      i_clk,
  input  wire sdpr_pkg::sdpr_stack_mem_t i_mem,
  input  wire logic                [7:0] i_wdata,
  output logic                     [7:0] o_rdata
);
  logic [7:0] ram [256];  // Stack contents.
  logic [7:0] held;       // Push data of the last cycle.
  logic [7:0] last;       // Last byte read out.

  // The core gives data with its push; it lands as the request shows.
  always_ff @(posedge i_clk) begin
    held <= i_wdata;
    if (i_mem.wr_en) begin
      ram[i_mem.addr] <= held;
    end
    if (i_mem.rd_en) begin
      last <= ram[i_mem.addr];
    end
  end

  // An idle read bus shows the inverse, so stale data never matches.
  assign o_rdata = i_mem.rd_en ? ram[i_mem.addr] : ~last;
endmodule

// File: testbench/sdpr_regs_tb.sv
`timescale 1ns/1ps

module sdpr_regs_tb;
  logic                      clk;         // 50 MHz clock.
  logic                      rstn;        // Reset, active low.
  sdpr_pkg::sdpr_sfr_req_t   req;         // Direct access.
  sdpr_pkg::sdpr_stack_op_t  op;          // Stack operation.
  logic                [7:0] rdata;       // Read data.
  logic                      hit;         // Address hit.
  logic                [7:0] stack_top;   // Stack pointer.
  logic               [15:0] dp;          // Wide pointer.
  sdpr_pkg::sdpr_stack_mem_t mem;         // Stack request.
  logic                [7:0] push_data;   // Data given with a push.
  logic                [7:0] ram_rdata;   // Data popped.
  int                        miscompares; // Failed checks.
  int                        checks;      // All checks.

  // ---------------------------------------------
  // Design, stack RAM and clock.
  // ---------------------------------------------
  sdpr_regs i_dut (
    .i_clk              (clk),
    .i_rstn             (rstn),
    .i_sfr_req          (req),
    .i_stack_op         (op),
    .o_sfr_rdata        (rdata),
    .o_sfr_hit          (hit),
    .o_stack_top_pointer(stack_top),
    .o_wide_data_pointer(dp),
    .o_stack_mem        (mem)
  );

  sdpr_stack_ram_model i_ram (
    .i_clk  (clk),
    .i_mem  (mem),
    .i_wdata(push_data),
    .o_rdata(ram_rdata)
  );

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ---------------------------------------------
  // Access and compare tasks.
  // ---------------------------------------------
  // One cycle of requests, driven at the falling edge; the answer is
  // looked at just after the next rising edge, where it stands.
  task automatic cyc(input logic w, input logic [7:0] a, input logic [7:0] d,
                     input sdpr_pkg::sdpr_stack_op_t o);
    @(negedge clk);
    req.wr_en = w;
    req.addr = a;
    req.wdata = d;
    op = o;
    @(posedge clk);
    #1;
  endtask

  task automatic chk_byte(input logic [7:0] g, input logic [7:0] e, input string s);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %0t %s got %h exp %h", $time, s, g, e);
    end
  endtask

  task automatic chk_word(input logic [15:0] g, input logic [15:0] e, input string s);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %0t %s got %h exp %h", $time, s, g, e);
    end
  endtask

  // Pushes with data, checking the write address and the new pointer.
  task automatic push(input logic [7:0] d, input logic [7:0] a);
    push_data = d;
    cyc(1'b0, 8'h00, 8'h00, sdpr_pkg::SDPR_OP_PUSH);
    chk_word({6'h00, mem}, {6'h00, 2'h2, a}, "push req");
    chk_byte(stack_top, a, "push pointer");
  endtask

  // Pops, checking read address, new pointer and the byte that comes back.
  task automatic pop(input logic [7:0] a, input logic [7:0] d);
    cyc(1'b0, 8'h00, 8'h00, sdpr_pkg::SDPR_OP_POP);
    chk_word({6'h00, mem}, {6'h00, 2'h1, a}, "pop req");
    chk_byte(stack_top, a - 8'h01, "pop pointer");
    chk_byte(ram_rdata, d, "pop data");
  endtask

  task automatic wrap_up();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ---------------------------------------------
  // Main sequence.
  // ---------------------------------------------
  initial begin
    rstn = 1'b0;
    req = '0;
    op = sdpr_pkg::SDPR_OP_NONE;
    push_data = 8'h00;
    miscompares = 0;
    checks = 0;
    repeat (5) @(negedge clk);
    rstn = 1'b1;
    cyc(1'b0, 8'h81, 8'h00, sdpr_pkg::SDPR_OP_NONE);
    chk_byte(stack_top, 8'h07, "reset pointer");
    chk_word(dp, 16'h0707, "reset dp");
    // Every pointer byte reads back its reset value with a hit.
    for (int i = 1; i < 4; i++) begin
      cyc(1'b0, 8'h80 + 8'(i), 8'h00, sdpr_pkg::SDPR_OP_NONE);
      chk_byte({hit, rdata[6:0]}, 8'h87, "reset read");
    end
    // Reserved-free bytes are written with plain values; the stack byte is
    // read straight back so that the readback path is exercised too.
    cyc(1'b1, 8'h81, 8'hFE, sdpr_pkg::SDPR_OP_NONE);
    cyc(1'b0, 8'h81, 8'h00, sdpr_pkg::SDPR_OP_NONE);
    chk_byte(rdata, 8'hFE, "stack read");
    cyc(1'b1, 8'h82, 8'h34, sdpr_pkg::SDPR_OP_NONE);
    cyc(1'b1, 8'h83, 8'h12, sdpr_pkg::SDPR_OP_NONE);
    chk_word(dp, 16'h1234, "wide pointer");
    chk_byte(stack_top, 8'hFE, "pointer write");
    cyc(1'b0, 8'h82, 8'h00, sdpr_pkg::SDPR_OP_NONE);
    chk_byte(rdata, 8'h34, "low read");
    cyc(1'b0, 8'h83, 8'h00, sdpr_pkg::SDPR_OP_NONE);
    chk_byte(rdata, 8'h12, "high read");
    // Other addresses of the space are not these registers.
    cyc(1'b1, 8'h84, 8'hA5, sdpr_pkg::SDPR_OP_NONE);
    cyc(1'b0, 8'h84, 8'h00, sdpr_pkg::SDPR_OP_NONE);
    chk_byte({7'h00, hit}, 8'h00, "unmapped hit");
    chk_byte(rdata, 8'h00, "unmapped read");
    cyc(1'b1, 8'h80, 8'hA5, sdpr_pkg::SDPR_OP_NONE);
    chk_word(dp, 16'h1234, "unmapped write");
    chk_byte(stack_top, 8'hFE, "unmapped pointer");
    // A direct address below the special space leaves the pointers alone.
    cyc(1'b1, 8'h01, 8'hA5, sdpr_pkg::SDPR_OP_NONE);
    chk_byte({7'h00, hit}, 8'h00, "low hit");
    chk_byte(stack_top, 8'hFE, "low write");
    // Pushes across the wrap, then one against a direct write.
    push(8'h11, 8'hFF);
    push(8'h22, 8'h00);
    push_data = 8'h33;
    cyc(1'b1, 8'h81, 8'h55, sdpr_pkg::SDPR_OP_PUSH);
    chk_byte(stack_top, 8'h01, "op beats write");
    pop(8'h01, 8'h33);
    pop(8'h00, 8'h22);
    pop(8'hFF, 8'h11);
    // A second reset in mid-run, entered and left at falling edges with
    // no stack operation pending, so the first edge after it stays idle.
    @(negedge clk);
    rstn = 1'b0;
    op = sdpr_pkg::SDPR_OP_NONE;
    @(negedge clk);
    rstn = 1'b1;
    cyc(1'b0, 8'h83, 8'h00, sdpr_pkg::SDPR_OP_NONE);
    chk_byte(stack_top, 8'h07, "second reset");
    chk_word(dp, 16'h0707, "second reset dp");
    chk_byte(rdata, 8'h07, "second reset read");
    // The first push after reset lands at the first location above 0x07.
    push(8'h44, 8'h08);
    pop(8'h08, 8'h44);
    wrap_up();
  end
endmodule
